// file: pkg/adcr_pkg.sv
// adcr_pkg: shared constants of the serial converter readout link
// assumes both ends run their local logic from a 200 MHz clock
package adcr_pkg;

  // result framing
  localparam int RESULT_BITS       = 12;
  localparam int FRAME_CLOCKS      = 13;  // leading one plus twelve bits
  localparam int BYTE_FRAME_CLOCKS = 16;  // two byte reads, three trailing zeros
  localparam int FULL_SCALE_CODES  = 4096;
  localparam int BIT_CNT_W         = 5;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_SAT = 5'h1f;

  // times in their own units
  localparam int CLK_PERIOD_NS     = 5;
  localparam int CONV_TIME_NS      = 8500;  // longest conversion
  localparam int ACQ_WAIT_NS       = 1500;  // acquisition_wait, least
  localparam int DESELECT_WAIT_NS  = 500;   // deselect_wait, least
  localparam int SCLK_MIN_PERIOD_NS = 400;  // 2.5 MHz ceiling

  // derived cycle counts
  localparam int WAIT_W = 11;
  localparam logic [WAIT_W-1:0] DEV_CONV_CYCLES =
    WAIT_W'(CONV_TIME_NS / CLK_PERIOD_NS);
  localparam logic [WAIT_W-1:0] HOST_CONV_CYCLES =
    WAIT_W'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [WAIT_W-1:0] ACQ_WAIT_CYCLES =
    WAIT_W'((ACQ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [WAIT_W-1:0] DESELECT_WAIT_CYCLES =
    WAIT_W'((DESELECT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int HALF_W = 6;
  localparam logic [HALF_W-1:0] SCLK_HALF_CYCLES =
    HALF_W'((SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // result buffer
  localparam int FIFO_DEPTH = 8;

endpackage

// file: pkg/adcr_link_if.sv
// adcr_link_if: the three-wire link between converter and host
// assumes the bench supplies a pull-down on the data wire when undriven
`timescale 1ns/100ps
interface adcr_link_if;
  logic cs_n;      // chip select, active low, host driven
  logic sclk;      // serial clock, host driven
  logic dout_val;  // device data value
  logic dout_oe;   // device drives data while high
  logic dout;      // resolved wire level

  // undriven wire reads low through the pull-down
  assign dout = dout_oe ? dout_val : 1'b0;

  modport dev  (input cs_n, input sclk, output dout_val, output dout_oe);
  modport host (output cs_n, output sclk, input dout);
endinterface // adcr_link_if

// file: verilog/adcr_device.sv
// adcr_device: converter end, internal conversion timer and serial shifter
// assumes the host keeps sclk idle during conversion and frames with cs_n
`timescale 1ns/100ps
module adcr_device (
  // local clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // held analog level as a code
  input  wire logic [adcr_pkg::RESULT_BITS-1:0] ain_code,
  // link
  adcr_link_if.dev                              link
);

  logic                              cs_meta;
  logic                              cs_sync;
  logic                              cs_prev;
  logic                              busy;
  logic                              eoc;
  logic                              oe;
  logic [adcr_pkg::WAIT_W-1:0]       conv_cnt;
  logic [adcr_pkg::RESULT_BITS-1:0]  held;
  logic [adcr_pkg::RESULT_BITS-1:0]  result;
  logic [adcr_pkg::BIT_CNT_W-1:0]    bit_cnt;
  logic                              edge_seen;
  logic                              shift_bit;

  // chip select from the pin, two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_prev <= 1'b1;
      cs_sync <= 1'b1;
    end else begin
      cs_meta <= link.cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // output enable follows select; high impedance when deselected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe <= 1'b0;
    end else begin
      oe <= ~cs_sync;  // R17 R18
    end
  end

  // internally timed conversion; select rising aborts it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      eoc      <= 1'b0;
      conv_cnt <= '0;
      held     <= '0;
      result   <= '0;
    end else if (cs_sync) begin
      busy <= 1'b0;  // R12
      eoc  <= 1'b0;  // R18
    end else if (cs_prev) begin
      busy     <= 1'b1;  // R13
      eoc      <= 1'b0;  // R13
      conv_cnt <= '0;
      held     <= ain_code;  // R4
    end else if (busy) begin
      if (conv_cnt == adcr_pkg::DEV_CONV_CYCLES - 1'b1) begin
        busy   <= 1'b0;
        eoc    <= 1'b1;  // R13
        result <= held;  // R4
      end else begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  // shifter on the link clock; result is stable once eoc is high, so the
  // word needs no further crossing. select high clears unread bits at once.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt   <= '0;  // R18
      edge_seen <= 1'b0;
      shift_bit <= 1'b0;
    end else begin
      edge_seen <= 1'b1;
      if (bit_cnt != adcr_pkg::BIT_CNT_SAT) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (bit_cnt < adcr_pkg::BIT_CNT_W'(adcr_pkg::RESULT_BITS)) begin
        shift_bit <= result[adcr_pkg::RESULT_BITS - 1 - int'(bit_cnt)];  // R8
      end else begin
        shift_bit <= 1'b0;  // R10
      end
    end
  end

  // before the first falling edge the wire shows the end-of-conversion level
  assign link.dout_val = edge_seen ? shift_bit : eoc;  // R13
  assign link.dout_oe  = oe;

endmodule // adcr_device

// file: verilog/adcr_host.sv
// adcr_host: host end, starts conversions, clocks out results into a FIFO
// assumes the device end sits across adcr_link_if; user drains the FIFO
// How it works
// R1 - use end-of-conversion edge, then 13 fast clocks
// R2 - raise select only after the last bit
// R3 - wait acquisition time before next start
// R4 - result is straight binary, 4096 codes
// R5 - host makes sclk, at most 2.5 MHz
// R6 - select low starts conversion, sclk held low
// R7 - clock only after timeout or data rising
// R8 - device shifts MSB first on falling edges
// R9 - host samples data on rising edges
// R10 - select rises at or after 13th falling edge
// R11 - wait deselect time while select is high
// R12 - early select rise aborts; then wait acquisition
// R13 - select fall starts conversion; data high marks end
// R14 - clock idles low, sample on leading edge
// R15 - byte mode: lead plus 7, then 5 plus 3 zeros
// R16 - sclk idle through the whole conversion
// R17 - data high impedance while deselected
// R18 - select rise floats data, drops unread bits
`timescale 1ns/100ps

// fifo: simple count-based buffer in flip-flops
module adcr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign in_ready  = (count != DEPTH_CNT);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // adcr_fifo

module adcr_host (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // control
  input  wire logic                             conv_en,
  input  wire logic                             byte_mode,
  input  wire logic                             abort_req,
  // results
  output logic                                  rd_valid,
  input  wire logic                             rd_ready,
  output logic [adcr_pkg::RESULT_BITS-1:0]      rd_data,
  output logic                                  busy,
  // link
  adcr_link_if.host                             link
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CONV  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_PUSH  = 3'h3,
    ST_WAIT  = 3'h4
  } adcr_host_state_type;

  adcr_host_state_type               state;
  logic                              cs_n;
  logic                              sclk;
  logic                              mode16;
  logic                              dout_meta;
  logic                              dout_sync;
  logic                              dout_prev;
  logic                              dout_rise;
  logic [adcr_pkg::WAIT_W-1:0]       wait_cnt;
  logic [adcr_pkg::HALF_W-1:0]       div_cnt;
  logic [adcr_pkg::BIT_CNT_W-1:0]    fall_cnt;
  logic [adcr_pkg::BIT_CNT_W-1:0]    frame_len;
  logic [adcr_pkg::BYTE_FRAME_CLOCKS-1:0] shreg;
  logic                              push_valid;
  logic                              push_ready;
  logic [adcr_pkg::RESULT_BITS-1:0]  push_data;
  logic                              half_done;
  logic                              wait_done;

  // data wire from the other end, two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
      dout_prev <= 1'b0;
    end else begin
      dout_meta <= link.dout;
      dout_sync <= dout_meta;
      dout_prev <= dout_sync;
    end
  end

  assign dout_rise = dout_sync & ~dout_prev;
  assign half_done = (div_cnt == adcr_pkg::SCLK_HALF_CYCLES - 1'b1);
  // both the acquisition and the deselect waits must have run out
  assign wait_done = (wait_cnt >= adcr_pkg::ACQ_WAIT_CYCLES) &&  // R3 R12
                     (wait_cnt >= adcr_pkg::DESELECT_WAIT_CYCLES);  // R11
  assign frame_len = mode16 ? adcr_pkg::BIT_CNT_W'(adcr_pkg::BYTE_FRAME_CLOCKS)
                            : adcr_pkg::BIT_CNT_W'(adcr_pkg::FRAME_CLOCKS);  // R1 R15

  // in byte mode the lead sits above the result and three zeros below it
  assign push_data  = mode16 ? shreg[adcr_pkg::BYTE_FRAME_CLOCKS-2 -: adcr_pkg::RESULT_BITS]
                             : shreg[adcr_pkg::RESULT_BITS-1:0];  // R4 R15
  assign push_valid = (state == ST_PUSH);

  // frame sequencer; a start waits for FIFO room, so a stalled reader
  // stops conversions instead of losing results
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      cs_n     <= 1'b1;
      sclk     <= 1'b0;
      mode16   <= 1'b0;
      wait_cnt <= adcr_pkg::ACQ_WAIT_CYCLES;
      div_cnt  <= '0;
      fall_cnt <= '0;
      shreg    <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          sclk <= 1'b0;  // R6 R14
          if (conv_en && push_ready) begin
            cs_n     <= 1'b0;  // R6
            mode16   <= byte_mode;
            wait_cnt <= '0;
            state    <= ST_CONV;
          end
        end
        ST_CONV: begin
          // clock held idle during conversion
          sclk <= 1'b0;  // R16
          if (abort_req) begin
            cs_n     <= 1'b1;  // R12
            wait_cnt <= '0;
            state    <= ST_WAIT;
          end else if (dout_rise || wait_cnt == adcr_pkg::HOST_CONV_CYCLES) begin
            div_cnt  <= '0;  // R7
            fall_cnt <= '0;
            state    <= ST_SHIFT;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        ST_SHIFT: begin
          if (abort_req) begin
            cs_n     <= 1'b1;  // R12
            sclk     <= 1'b0;
            wait_cnt <= '0;
            state    <= ST_WAIT;
          end else if (half_done) begin
            div_cnt <= '0;
            if (!sclk) begin
              sclk  <= 1'b1;  // R5 R14
              shreg <= {shreg[adcr_pkg::BYTE_FRAME_CLOCKS-2:0], dout_sync};  // R9
            end else begin
              sclk     <= 1'b0;
              fall_cnt <= fall_cnt + 1'b1;
              if (fall_cnt + 1'b1 == frame_len) begin
                state <= ST_PUSH;  // R10
              end
            end
          end else begin
            div_cnt <= div_cnt + 1'b1;
          end
        end
        ST_PUSH: begin
          // room was checked at start, so the push is taken here
          cs_n     <= 1'b1;  // R2 R10
          wait_cnt <= '0;
          state    <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_done) begin
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cs_n  <= 1'b1;
          sclk  <= 1'b0;
        end
      endcase
    end
  end

  // busy flag as a flop so the output is clean
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != ST_IDLE);
    end
  end

  // result buffer between the link and the reader
  adcr_fifo #(
    .WIDTH (adcr_pkg::RESULT_BITS),
    .DEPTH (adcr_pkg::FIFO_DEPTH)
  ) i_adcr_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign link.cs_n = cs_n;
  assign link.sclk = sclk;

endmodule // adcr_host

// file: verif/adcr_link_properties.sv
// adcr_link_checker: timing properties of the converter readout link
// assumes link wires sampled on the host clock, device logic may be async
`timescale 1ns/100ps
module adcr_link_checker (
  // host clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_val,
  input wire logic dout_oe,
  input wire logic dout
);
  logic        eoc_seen;
  logic        sclk_q;
  logic [10:0] conv_cnt;
  logic [8:0]  cs_hi_cnt;
  logic [6:0]  half_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // end of conversion seen in this frame, cleared by deselect
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      eoc_seen <= 1'h0;
    end else if (dout_oe && dout) begin
      eoc_seen <= 1'h1;
    end
  end

  // conversion length, saturating so a stuck device still fails
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n || eoc_seen) begin
      conv_cnt <= 11'h0;
    end else if (conv_cnt != 11'h7ff) begin
      conv_cnt <= conv_cnt + 11'h1;
    end
  end

  // deselect time; starts satisfied because the host leaves reset idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_hi_cnt <= 9'h12c;
    end else if (!cs_n) begin
      cs_hi_cnt <= 9'h0;
    end else if (cs_hi_cnt != 9'h12c) begin
      cs_hi_cnt <= cs_hi_cnt + 9'h1;
    end
  end

  // length of each serial clock phase
  always_ff @(posedge clk) begin
    sclk_q <= rst_n ? sclk : 1'h0;
    if (!rst_n || sclk != sclk_q) begin
      half_cnt <= 7'h0;
    end else if (half_cnt != 7'h7f) begin
      half_cnt <= half_cnt + 7'h1;
    end
  end

  a_start_clk_low: assert property ($fell(cs_n) |-> !sclk)
    else $error("serial clock high at conversion start");
  a_idle_in_conv: assert property (!cs_n && !eoc_seen |-> !sclk)
    else $error("serial clock moved before end of conversion");
  a_conv_bound: assert property (conv_cnt <= 11'd1710)
    else $error("end of conversion came too late");
  a_start_drive: assert property ($fell(cs_n) |-> ##[1:6] (dout_oe && !dout_val))
    else $error("data not driven low after select fell");
  a_float_desel: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("data still driven after select rose");
  a_shift_fall: assert property (!cs_n && $past(eoc_seen) && dout != $past(dout)
    |-> !sclk && ($past(sclk) || $past(sclk, 2)))
    else $error("data changed away from a falling clock edge");
  a_half_period: assert property (sclk != sclk_q |-> half_cnt >= 7'd39)
    else $error("serial clock phase too short");
  a_acq_wait: assert property ($fell(cs_n) |-> cs_hi_cnt >= 9'd300)
    else $error("select low again too soon");
endmodule // adcr_link_checker

// file: verif/tb_adc_serial_result_readout.sv
// tb_adc_serial_result_readout: both link ends joined, results and wire checked
// assumes a 200 MHz host clock and a free device clock of another period
`timescale 1ns/100ps
module tb_adc_serial_result_readout;
  logic        clk;
  logic        dclk;
  logic        rst_n;
  logic        conv_en;
  logic        byte_mode;
  logic        abort_req;
  logic        rd_ready;
  logic        rd_valid;
  logic        busy;
  logic [11:0] ain_code;
  logic [11:0] rd_data;
  logic [15:0] shreg;
  int          nbits;
  int          errors;
  int          cmp_count;
  int          cyc;

  adcr_link_if link ();
  adcr_device i_adcr_device (.clk(dclk), .rst_n(rst_n), .ain_code(ain_code), .link(link));
  adcr_host i_adcr_host (.clk(clk), .rst_n(rst_n), .conv_en(conv_en), .byte_mode(byte_mode),
    .abort_req(abort_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .busy(busy), .link(link));
  adcr_link_checker i_adcr_link_checker (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .dout_val(link.dout_val), .dout_oe(link.dout_oe), .dout(link.dout));

  // host clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // device clock a little faster, so it always beats the host timeout
  initial begin
    dclk = 1'h0;
    #1.1;
    forever #2.4 dclk = ~dclk;
  end

  // what a host sees on each rising serial clock edge
  always @(posedge link.sclk) begin
    shreg <= {shreg[14:0], link.dout};
    nbits <= nbits + 1;
  end
  always @(negedge link.cs_n) nbits <= 0;

  // hang guard, the run needs about 60000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one whole frame, then the wire stream is judged
  task automatic convert(input logic [11:0] code, input logic bm);
    ain_code  <= code;
    byte_mode <= bm;
    conv_en   <= 1'h1;
    @(posedge clk);
    while (link.cs_n !== 1'h0) @(posedge clk);
    conv_en <= 1'h0;
    while (link.cs_n !== 1'h1) @(posedge clk);
    repeat (10) @(posedge clk);
    chk("data enable", 16'h0, {15'h0, link.dout_oe});
    chk("busy in wait", 16'h1, {15'h0, busy});
    if (bm) begin
      chk("bit count", 16'h10, 16'(nbits));
      chk("byte stream", {1'h1, code, 3'h0}, shreg);
    end else begin
      chk("bit count", 16'h0d, 16'(nbits));
      chk("frame", {4'h1, code}, {3'h0, shreg[12:0]});
    end
  endtask

  // take the head word; extra edge lets the pop land before the next look
  task automatic pop_chk(input logic [11:0] exp);
    while (rd_valid !== 1'h1) @(posedge clk);
    chk("result", {4'h0, exp}, {4'h0, rd_data});
    rd_ready <= 1'h1;
    @(posedge clk);
    rd_ready <= 1'h0;
    @(posedge clk);
  endtask

  // range ends and alternating bits
  task automatic t_codes();
    logic [11:0] codes [6] = '{12'h000, 12'hfff, 12'ha5a, 12'h5a5, 12'h800, 12'h001};
    foreach (codes[i]) begin
      convert(codes[i], 1'h0);
      pop_chk(codes[i]);
    end
    $display("codes done");
  endtask

  task automatic t_bytes();
    convert(12'hc3e, 1'h1);
    pop_chk(12'hc3e);
    convert(12'h01f, 1'h1);
    pop_chk(12'h01f);
    $display("bytes done");
  endtask

  // abort in conversion, then in mid shift; no word may appear
  task automatic t_abort();
    ain_code  <= 12'h3c3;
    byte_mode <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      conv_en <= 1'h1;
      @(posedge clk);
      while (link.cs_n !== 1'h0) @(posedge clk);
      conv_en <= 1'h0;
      while (k == 1 && link.sclk !== 1'h1) @(posedge clk);
      repeat (200) @(posedge clk);
      abort_req <= 1'h1;
      repeat (8) @(posedge clk);
      chk("select after abort", 16'h1, {15'h0, link.cs_n});
      abort_req <= 1'h0;
      repeat (400) @(posedge clk);
      chk("word after abort", 16'h0, {15'h0, rd_valid});
    end
    convert(12'h7e1, 1'h0);
    pop_chk(12'h7e1);
    $display("abort done");
  endtask

  // fill while the reader stalls, starts refused when full, drain in order
  task automatic t_fifo();
    for (int k = 0; k < 8; k++) begin
      convert(12'h100 + 12'(k), 1'h0);
    end
    conv_en <= 1'h1;
    repeat (2000) @(posedge clk);
    chk("select while full", 16'h1, {15'h0, link.cs_n});
    chk("busy while full", 16'h0, {15'h0, busy});
    conv_en <= 1'h0;
    for (int k = 0; k < 8; k++) begin
      pop_chk(12'h100 + 12'(k));
    end
    chk("empty", 16'h0, {15'h0, rd_valid});
    $display("buffer done");
  endtask

  initial begin
    rst_n     = 1'h0;
    conv_en   = 1'h0;
    byte_mode = 1'h0;
    abort_req = 1'h0;
    rd_ready  = 1'h0;
    ain_code  = 12'h0;
    shreg     = 16'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_codes();
    t_bytes();
    t_abort();
    t_fifo();
    complete_run();
  end
endmodule // tb_adc_serial_result_readout
